// file: common/tms_pkg.sv
// Constants, register map and carrier types of the 8-bit timer mode sequencer.
// Assumes a 32-bit APB slave port and one core clock for all logic.
package tms_pkg;

  // Register byte offsets
  localparam logic [11:0] TMS_CTRL_OFS = 12'h000;
  localparam logic [11:0] TMS_COUNT_OFS = 12'h004;
  localparam logic [11:0] TMS_COMPARE_OFS = 12'h008;
  localparam logic [11:0] TMS_FLAGS_OFS = 12'h00c;
  localparam logic [11:0] TMS_STATUS_OFS = 12'h010;

  // Control register fields
  localparam int TMS_CTRL_WIDTH = 9;
  localparam int TMS_FORCE_BIT = 9;
  localparam logic [8:0] TMS_CTRL_RESET = 9'h000;

  // Flag register fields
  localparam int TMS_WRAP_BIT = 0;
  localparam int TMS_MATCH_BIT = 1;

  // Status register fields
  localparam int TMS_STAT_OC_BIT = 8;

  // Counter extremes
  localparam logic [7:0] TMS_BOTTOM = 8'h00;
  localparam logic [7:0] TMS_MAX = 8'hff;
  localparam logic [7:0] TMS_MAX_M1 = 8'hfe;

  // Prescaler: divide-by counts minus one for the selectable factors
  localparam logic [9:0] TMS_DIV1_LIM = 10'h000;
  localparam logic [9:0] TMS_DIV8_LIM = 10'h007;
  localparam logic [9:0] TMS_DIV32_LIM = 10'h01f;
  localparam logic [9:0] TMS_DIV64_LIM = 10'h03f;
  localparam logic [9:0] TMS_DIV128_LIM = 10'h07f;
  localparam logic [9:0] TMS_DIV256_LIM = 10'h0ff;
  localparam logic [9:0] TMS_DIV1024_LIM = 10'h3ff;

  // Waveform modes, numbered as the mode field encodes them
  typedef enum logic [1:0] {
    TMS_MODE_NORMAL = 2'h0,
    TMS_MODE_PHASE = 2'h1,
    TMS_MODE_CLEAR_ON_MATCH = 2'h2,
    TMS_MODE_FAST_PWM = 2'h3
  } tms_mode_e;

  // Output actions
  typedef enum logic [1:0] {
    TMS_ACT_NONE = 2'h0,
    TMS_ACT_TOGGLE = 2'h1,
    TMS_ACT_CLEAR = 2'h2,
    TMS_ACT_SET = 2'h3
  } tms_action_e;

  // Control register layout, bit 0 upward from the right
  typedef struct packed {
    logic port_level;
    logic pin_dir;
    logic [2:0] clk_sel;
    tms_action_e out_action_sel;
    tms_mode_e wave_mode_sel;
  } tms_ctrl_s;

endpackage

// file: hw/tms_timer8.sv
// 8-bit timer/counter with normal, clear-on-match and fast PWM sequencing,
// a compare output driving one port pin, and an APB register slave.
// Assumes APB signals synchronous to i_core_clk; the pin pad is outside.
`timescale 1ns/1ps

module tms_timer8 (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // Flag service acknowledges from an interrupt controller
  input wire logic i_wrap_ack,
  input wire logic i_match_ack,
  // Flag levels
  output logic o_wrap_flag,
  output logic o_match_flag,
  // Compare output pin
  output logic o_cmp_pin_out,
  output logic o_cmp_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  tms_pkg::tms_ctrl_s ctrl_reg;
  logic [7:0] count_value_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] compare_buf_reg;
  logic wrap_flag_reg;
  logic match_flag_reg;
  logic match_pend_reg;
  logic block_reg;
  logic compare_output_reg;
  logic [9:0] presc_cnt_reg;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pin_out_reg;
  logic pin_oe_reg;

  logic [9:0] presc_lim;
  logic tick;
  logic is_pwm;
  logic cmp_hit;
  logic match_now;
  logic at_top;
  logic wrap_set;
  logic [7:0] count_value_next;
  logic compare_output_next;
  logic hit_ctrl;
  logic hit_count;
  logic hit_compare;
  logic hit_flags;
  logic hit_status;
  logic setup;
  logic wr_xfer;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  always_comb begin
    case (ctrl_reg.clk_sel)
      3'h1: presc_lim = tms_pkg::TMS_DIV1_LIM;
      3'h2: presc_lim = tms_pkg::TMS_DIV8_LIM;
      3'h3: presc_lim = tms_pkg::TMS_DIV32_LIM;
      3'h4: presc_lim = tms_pkg::TMS_DIV64_LIM;
      3'h5: presc_lim = tms_pkg::TMS_DIV128_LIM;
      3'h6: presc_lim = tms_pkg::TMS_DIV256_LIM;
      3'h7: presc_lim = tms_pkg::TMS_DIV1024_LIM;
      default: presc_lim = tms_pkg::TMS_DIV1_LIM;
    endcase
  end

  // Select 0 stops the timer; the phase restarts whenever the timer stops
  assign tick = (ctrl_reg.clk_sel != 3'h0) && (presc_cnt_reg == presc_lim);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      presc_cnt_reg <= 10'h000;
    end else if (ctrl_reg.clk_sel == 3'h0 || tick) begin
      presc_cnt_reg <= 10'h000;
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  always_comb begin
    hit_ctrl = 1'b0;
    hit_count = 1'b0;
    hit_compare = 1'b0;
    hit_flags = 1'b0;
    hit_status = 1'b0;
    if (i_paddr == tms_pkg::TMS_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (i_paddr == tms_pkg::TMS_COUNT_OFS) begin
      hit_count = 1'b1;
    end else if (i_paddr == tms_pkg::TMS_COMPARE_OFS) begin
      hit_compare = 1'b1;
    end else if (i_paddr == tms_pkg::TMS_FLAGS_OFS) begin
      hit_flags = 1'b1;
    end else if (i_paddr == tms_pkg::TMS_STATUS_OFS) begin
      hit_status = 1'b1;
    end
  end

  assign setup = i_psel && !i_penable;
  assign wr_xfer = i_psel && i_penable && pready_reg && i_pwrite;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux[tms_pkg::TMS_CTRL_WIDTH-1:0] = ctrl_reg;
    end else if (hit_count) begin
      rd_mux[7:0] = count_value_reg;
    end else if (hit_compare) begin
      rd_mux[7:0] = compare_buf_reg;
    end else if (hit_flags) begin
      rd_mux[tms_pkg::TMS_WRAP_BIT] = wrap_flag_reg;
      rd_mux[tms_pkg::TMS_MATCH_BIT] = match_flag_reg;
    end else if (hit_status) begin
      rd_mux[7:0] = compare_value_reg;
      rd_mux[tms_pkg::TMS_STAT_OC_BIT] = compare_output_reg;
    end
  end

  // Answer is registered in the setup cycle so the access phase lasts one cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= !(hit_ctrl || hit_count || hit_compare || hit_flags || hit_status);
      end else begin
        prdata_reg <= 32'h0000_0000;
        pslverr_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ctrl_reg <= tms_pkg::TMS_CTRL_RESET;
    end else if (wr_xfer && hit_ctrl) begin
      ctrl_reg <= i_pwdata[tms_pkg::TMS_CTRL_WIDTH-1:0];
    end
  end

  assign is_pwm = (ctrl_reg.wave_mode_sel == tms_pkg::TMS_MODE_FAST_PWM) ||
                  (ctrl_reg.wave_mode_sel == tms_pkg::TMS_MODE_PHASE);

  ////////////////////////////////////////////////////////////////////////////
  // Counter sequencing

  assign cmp_hit = (count_value_reg == compare_value_reg);
  // A count write blocks the match of the next tick, so equal start values stay quiet
  assign match_now = tick && cmp_hit && !block_reg;
  assign at_top = (count_value_reg == tms_pkg::TMS_MAX);

  always_comb begin
    count_value_next = count_value_reg;
    if (tick) begin
      case (ctrl_reg.wave_mode_sel)
        tms_pkg::TMS_MODE_CLEAR_ON_MATCH: begin
          // A compare below the count misses and the count wraps through 0xFF first
          if (match_now) begin
            count_value_next = tms_pkg::TMS_BOTTOM;
          end else begin
            count_value_next = count_value_reg + 8'h01;
          end
        end
        tms_pkg::TMS_MODE_FAST_PWM: begin
          if (at_top) begin
            count_value_next = tms_pkg::TMS_BOTTOM;
          end else begin
            count_value_next = count_value_reg + 8'h01;
          end
        end
        default: begin
          count_value_next = count_value_reg + 8'h01;
        end
      endcase
    end
  end

  // Software write wins over the tick and is taken with no mode restriction
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      count_value_reg <= tms_pkg::TMS_BOTTOM;
    end else if (wr_xfer && hit_count) begin
      count_value_reg <= i_pwdata[7:0];
    end else begin
      count_value_reg <= count_value_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      block_reg <= 1'b0;
    end else if (wr_xfer && hit_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare value and its buffer

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      compare_buf_reg <= tms_pkg::TMS_BOTTOM;
    end else if (wr_xfer && hit_compare) begin
      compare_buf_reg <= i_pwdata[7:0];
    end
  end

  // The buffered load at top keeps PWM pulses whole when the duty changes
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      compare_value_reg <= tms_pkg::TMS_BOTTOM;
    end else if (!is_pwm && wr_xfer && hit_compare) begin
      compare_value_reg <= i_pwdata[7:0];
    end else if (is_pwm && tick && at_top) begin
      compare_value_reg <= compare_buf_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags

  always_comb begin
    case (ctrl_reg.wave_mode_sel)
      tms_pkg::TMS_MODE_FAST_PWM: wrap_set = tick && (count_value_reg == tms_pkg::TMS_MAX_M1);
      tms_pkg::TMS_MODE_CLEAR_ON_MATCH: wrap_set = tick && at_top;
      default: wrap_set = tick && at_top;
    endcase
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wrap_flag_reg <= 1'b0;
    end else if (wrap_set && !(wr_xfer && hit_count)) begin
      wrap_flag_reg <= 1'b1;
    end else if (i_wrap_ack || (wr_xfer && hit_flags && i_pwdata[tms_pkg::TMS_WRAP_BIT])) begin
      wrap_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      match_pend_reg <= 1'b0;
    end else if (tick) begin
      match_pend_reg <= match_now;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      match_flag_reg <= 1'b0;
    end else if (tick && match_pend_reg) begin
      match_flag_reg <= 1'b1;
    end else if (i_match_ack || (wr_xfer && hit_flags && i_pwdata[tms_pkg::TMS_MATCH_BIT])) begin
      match_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare output

  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      tms_pkg::TMS_ACT_TOGGLE: apply_action = !cur;
      tms_pkg::TMS_ACT_CLEAR: apply_action = 1'b0;
      tms_pkg::TMS_ACT_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction

  always_comb begin
    compare_output_next = compare_output_reg;
    if (!is_pwm && wr_xfer && hit_ctrl && i_pwdata[tms_pkg::TMS_FORCE_BIT]) begin
      // Forced match uses the action being written, with no flag and no clear
      compare_output_next = apply_action(i_pwdata[3:2], compare_output_reg);
    end else if (ctrl_reg.wave_mode_sel == tms_pkg::TMS_MODE_FAST_PWM) begin
      // Bottom wins over a match at max, giving a steady level for compare = max with action clear or set
      if (tick && at_top && ctrl_reg.out_action_sel == tms_pkg::TMS_ACT_CLEAR) begin
        compare_output_next = 1'b1;
      end else if (tick && at_top && ctrl_reg.out_action_sel == tms_pkg::TMS_ACT_SET) begin
        compare_output_next = 1'b0;
      end else if (match_now) begin
        compare_output_next = apply_action(ctrl_reg.out_action_sel, compare_output_reg);
      end
    end else if (!is_pwm && match_now) begin
      compare_output_next = apply_action(ctrl_reg.out_action_sel, compare_output_reg);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      compare_output_reg <= 1'b0;
    end else begin
      compare_output_reg <= compare_output_next;
    end
  end

  // Action none hands the pin back to the plain port level
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_out_reg <= (ctrl_reg.out_action_sel != tms_pkg::TMS_ACT_NONE) ?
                     compare_output_reg : ctrl_reg.port_level;
      pin_oe_reg <= ctrl_reg.pin_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_pready = pready_reg;
  assign o_prdata = prdata_reg;
  assign o_pslverr = pslverr_reg;
  assign o_wrap_flag = wrap_flag_reg;
  assign o_match_flag = match_flag_reg;
  assign o_cmp_pin_out = pin_out_reg;
  assign o_cmp_pin_oe = pin_oe_reg;

endmodule

// file: verification/tms_pin_pad.sv
// Pad model for the compare output pin, with a weak pull-up.
// Assumes the block drives the pad only through its value and enable pins.
`timescale 1ns/1ps
module tms_pin_pad (
  // Block side
  input wire logic i_out,
  input wire logic i_oe,
  // Pad level
  output logic o_level
);
  // Undriven pad floats up, so a lost enable never reads as a driven low
  assign o_level = i_oe ? i_out : 1'b1;
endmodule

// file: verification/tms_monitor.sv
// Port checker for the timer block: APB timing, flag clearing, pin enable.
// Assumes it is bound to tms_timer8 and sees its ports only.
`timescale 1ns/1ps
module tms_monitor (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  // Flags and pin
  input wire logic i_wrap_ack,
  input wire logic i_match_ack,
  input wire logic o_wrap_flag,
  input wire logic o_match_flag,
  input wire logic o_cmp_pin_out,
  input wire logic o_cmp_pin_oe
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  logic fl_wr;
  logic ctrl_wr;
  logic wrap_clr;
  logic match_clr;
  assign fl_wr = i_psel && i_penable && i_pwrite && i_paddr == tms_pkg::TMS_FLAGS_OFS;
  assign ctrl_wr = i_psel && i_penable && i_pwrite && i_paddr == tms_pkg::TMS_CTRL_OFS;
  assign wrap_clr = i_wrap_ack || fl_wr && i_pwdata[tms_pkg::TMS_WRAP_BIT];
  assign match_clr = i_match_ack || fl_wr && i_pwdata[tms_pkg::TMS_MATCH_BIT];
  ////////////////////////////////////////////////////////////////
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence
  property p_answer;
    s_setup ##1 s_access |-> o_pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no ready in access");
  property p_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_idle;
    !o_pready |-> o_prdata == 32'h0 && !o_pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("bus outputs not idle");
  property p_unmapped;
    i_psel && !i_penable && i_paddr > tms_pkg::TMS_STATUS_OFS |=> o_pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_reset;
    disable iff (1'b0)
    !i_nrst |=> !o_wrap_flag && !o_match_flag && !o_cmp_pin_oe && !o_pready;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs set after reset");
  property p_wrap_hold;
    $fell(o_wrap_flag) |-> $past(wrap_clr) || !$past(i_nrst);
  endproperty
  a_wrap_hold: assert property (p_wrap_hold) else $error("wrap flag lost");
  property p_match_hold;
    $fell(o_match_flag) |-> $past(match_clr) || !$past(i_nrst);
  endproperty
  a_match_hold: assert property (p_match_hold) else $error("match flag lost");
  property p_oe_src;
    $changed(o_cmp_pin_oe) |-> $past(ctrl_wr, 2) || !$past(i_nrst) || !$past(i_nrst, 2);
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("pin enable moved alone");
endmodule

bind tms_timer8 tms_monitor u_monitor (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_wrap_ack(i_wrap_ack),
  .i_match_ack(i_match_ack), .o_wrap_flag(o_wrap_flag), .o_match_flag(o_match_flag),
  .o_cmp_pin_out(o_cmp_pin_out), .o_cmp_pin_oe(o_cmp_pin_oe)
);

// file: verification/testbench.sv
// Testbench for the timer block: APB call sequences with expected values.
// Assumes an APB slave that answers by pready and a pull-up pad on the compare pin.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic wack = 1'b0;
  logic mack = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] q;
  logic [31:0] prdata;
  logic pready, pslverr, perr, wflag, mflag, pout, poe, pad;
  int n_errors = 0;
  int samples_checked = 0;
  int n, hi, lo;
  int lim[8] = '{1, 8, 32, 64, 128, 256, 1024, 3};
  logic [11:0] regs[5] = '{tms_pkg::TMS_CTRL_OFS, tms_pkg::TMS_COUNT_OFS,
    tms_pkg::TMS_COMPARE_OFS, tms_pkg::TMS_FLAGS_OFS, tms_pkg::TMS_STATUS_OFS};
  always #50 clk = ~clk;
  tms_timer8 dut (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_wrap_ack(wack), .i_match_ack(mack),
    .o_wrap_flag(wflag), .o_match_flag(mflag), .o_cmp_pin_out(pout), .o_cmp_pin_oe(poe));
  tms_pin_pad pad_model (.i_out(pout), .i_oe(poe), .o_level(pad));
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One idle cycle after each transfer keeps every signal to one change per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Cycles until the wrap flag is seen high, or until the pad level changes
  task automatic wait_ev(input bit flag, output int m);
    logic v;
    v = pad;
    m = 0;
    do begin
      @(posedge clk);
      m++;
    end while (flag ? wflag !== 1'b1 : pad === v);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] md, ac, input logic [2:0] s);
    return {23'h0, 2'b01, s, ac, md};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", q, 32'h0);
    end
    chk("idle pad", 32'(pad), 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped error", 32'(perr), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h0, 2'(i), 3'h0));
      apb(1'b1, tms_pkg::TMS_COUNT_OFS, 32'hf0);
      apb(1'b1, tms_pkg::TMS_COMPARE_OFS, 32'hf4);
      apb(1'b0, tms_pkg::TMS_COUNT_OFS, 32'h0);
      chk("count written", q, 32'hf0);
      apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h0, 2'(i), 3'h1));
      wait_ev(1'b1, n);
      chk("ticks to wrap", 32'(n), 32'd16);
      chk("match flag", 32'(mflag), 32'h1);
      apb(1'b1, tms_pkg::TMS_CTRL_OFS, 32'h0);
      wack <= (i == 0);
      mack <= (i == 0);
      @(posedge clk);
      wack <= 1'b0;
      mack <= 1'b0;
      apb(1'b1, tms_pkg::TMS_FLAGS_OFS, 32'(i * 3));
      apb(1'b0, tms_pkg::TMS_FLAGS_OFS, 32'h0);
      chk("flags cleared", q, 32'h0);
    end
    $display("test normal done");
    // Forced match with action clear, then set; ends with the output high
    for (int i = 2; i < 4; i++) begin
      apb(1'b1, tms_pkg::TMS_CTRL_OFS, 32'h280 | 32'(i << 2));
      apb(1'b0, tms_pkg::TMS_STATUS_OFS, 32'h0);
      chk("forced output", 32'(q[tms_pkg::TMS_STAT_OC_BIT]), 32'(i - 2));
      chk("forced pad", 32'(pad), 32'(i - 2));
    end
    apb(1'b0, tms_pkg::TMS_FLAGS_OFS, 32'h0);
    chk("force sets no flag", q, 32'h0);
    $display("test force done");
    apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h2, 2'h1, 3'h0));
    apb(1'b1, tms_pkg::TMS_COUNT_OFS, 32'h0a);
    apb(1'b1, tms_pkg::TMS_COMPARE_OFS, 32'h05);
    apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h2, 2'h1, 3'h1));
    wait_ev(1'b0, n);
    chk("missed match delay", 32'(n), 32'd253);
    chk("wrap flag", 32'(wflag), 32'h1);
    apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h2, 2'h1, 3'h0));
    apb(1'b1, tms_pkg::TMS_COUNT_OFS, 32'h0);
    apb(1'b1, tms_pkg::TMS_COMPARE_OFS, 32'h0);
    apb(1'b1, tms_pkg::TMS_FLAGS_OFS, 32'h3);
    for (int i = 0; i < 8; i++) begin
      if (i == 7)
        apb(1'b1, tms_pkg::TMS_COMPARE_OFS, 32'h02);
      apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h2, 2'h1, 3'(i == 7 ? 1 : i + 1)));
      wait_ev(1'b0, n);
      wait_ev(1'b0, n);
      chk("toggle spacing", 32'(n), 32'(lim[i]));
    end
    chk("match flag", 32'(mflag), 32'h1);
    $display("test clear on match done");
    apb(1'b1, tms_pkg::TMS_COMPARE_OFS, 32'h40);
    apb(1'b1, tms_pkg::TMS_FLAGS_OFS, 32'h1);
    for (int i = 2; i < 4; i++) begin
      apb(1'b1, tms_pkg::TMS_CTRL_OFS, cfg(2'h3, 2'(i), 3'h1));
      repeat (3) wait_ev(1'b0, n);
      if (pad !== 1'b1)
        wait_ev(1'b0, n);
      wait_ev(1'b0, hi);
      wait_ev(1'b0, lo);
      chk("high time", 32'(hi), i == 2 ? 32'd65 : 32'd191);
      chk("period", 32'(hi + lo), 32'd256);
    end
    chk("wrap flag", 32'(wflag), 32'h1);
    apb(1'b1, tms_pkg::TMS_COMPARE_OFS, 32'h80);
    apb(1'b0, tms_pkg::TMS_STATUS_OFS, 32'h0);
    chk("active compare held", q & 32'hff, 32'h40);
    repeat (300) @(posedge clk);
    apb(1'b0, tms_pkg::TMS_STATUS_OFS, 32'h0);
    chk("active compare loaded", q & 32'hff, 32'h80);
    $display("test fast pwm done");
    end_of_test();
  end
endmodule
